// File: hdl/level_sync.sv
`timescale 1ns/10ps
`default_nettype none

module level_sync (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // level
    input  wire logic async_in,
    output logic      sync_out
);

    logic stage1_ff;
    logic stage2_ff;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_out = stage2_ff;

endmodule
`default_nettype wire

// File: hdl/serial_port_pin_sharing.sv
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - serial enabled: data pin driven by serial data, pulldown off.
// - direction and data bits stay readable and writable while serial owns pins.
// - serial owns data pin, direction clear: data bit read returns pin level.
// - serial owns clock pin, direction clear: data bit read returns pin level.
// - serial disabled: data pin follows stored direction, pulldown-inhibit, data bits.
// - serial disabled: clock pin follows stored direction, pulldown-inhibit, data bits.
// - serial and direction clear make an input; pulldown-inhibit turns pulldown off.
// - serial clear, pulldown-inhibit set: data pin pulldown off, output enable follows the direction bit.
// - serial enabled: clock pin buffer follows master select, pulldown off.
// - enabled and master: clock pin driven with internal serial clock.
// - enabled and not master: clock pin released, peer supplies clock.
// - enabled serial unit bypasses port bits; port writes cannot disturb it.
module serial_port_pin_sharing
    import pin_share_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // serial unit
    input  wire logic        serial_data_out,
    input  wire logic        serial_clk_out,
    output logic             serial_clk_in,
    output logic             serial_enable,
    output logic             master_select,
    // shared data output pin
    input  wire logic        shared_dout_pin_in,
    output logic             shared_dout_pin_out,
    output logic             shared_dout_pin_oe,
    output logic             shared_dout_pin_pulldown_en,
    // shared clock pin
    input  wire logic        shared_clk_pin_in,
    output logic             shared_clk_pin_out,
    output logic             shared_clk_pin_oe,
    output logic             shared_clk_pin_pulldown_en
);

    function automatic reg_sel_type reg_decode(input logic [11:0] addr);
        reg_sel_type sel;
        sel = REG_NONE;
        unique case (addr)
            OFS_SERIAL_CTRL: sel = REG_SERIAL_CTRL;
            OFS_PORT_DIR:    sel = REG_PORT_DIR;
            OFS_PORT_DATA:   sel = REG_PORT_DATA;
            OFS_PULLDOWN_IN: sel = REG_PULLDOWN_IN;
            OFS_PIN_STATUS:  sel = REG_PIN_STATUS;
            default:         sel = REG_NONE;
        endcase
        return sel;
    endfunction

    function automatic logic [1:0] port_field(input logic [31:0] word);
        return {word[PORT_CLK_BIT], word[PORT_DOUT_BIT]};
    endfunction

    function automatic logic [31:0] port_word(input logic [1:0] bits);
        logic [31:0] word;
        word                = 32'h0000_0000;
        word[PORT_DOUT_BIT] = bits[PIN_DOUT];
        word[PORT_CLK_BIT]  = bits[PIN_CLK];
        return word;
    endfunction

    // control registers
    logic          serial_enable_ff;
    logic          nxt_serial_enable;
    logic          master_select_ff;
    logic          nxt_master_select;
    logic [1:0]    dir_ff;
    logic [1:0]    nxt_dir;
    logic [1:0]    data_ff;
    logic [1:0]    nxt_data;
    logic [1:0]    pdi_ff;
    logic [1:0]    nxt_pdi;

    // read path
    logic [31:0]   prdata_ff;
    logic [31:0]   nxt_prdata;
    logic          serial_clk_in_ff;
    logic          nxt_serial_clk_in;

    // bus decode
    reg_sel_type   sel;
    logic          setup_phase;
    logic          access_phase;
    logic          wr_take;

    // pin side
    logic [1:0]    pin_raw;
    logic [1:0]    pin_level;
    logic [1:0]    serial_drives;
    logic [1:0]    serial_value;
    port_bits_type port_bits [PIN_COUNT];
    pin_drive_type drive     [PIN_COUNT];
    logic [1:0]    drive_oe;
    logic [1:0]    drive_pd;
    logic [1:0]    owned;
    logic [1:0]    data_view;

    assign sel          = reg_decode(paddr);
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign wr_take      = access_phase && pwrite;

    assign pready  = 1'b1;
    assign pslverr = access_phase && (sel == REG_NONE ||
                     (pwrite && sel == REG_PIN_STATUS));

    assign pin_raw[PIN_DOUT] = shared_dout_pin_in;
    assign pin_raw[PIN_CLK]  = shared_clk_pin_in;

    // serial unit claims on each pin
    assign serial_drives[PIN_DOUT] = 1'b1;
    assign serial_drives[PIN_CLK]  = master_select_ff;
    assign serial_value[PIN_DOUT]  = serial_data_out;
    assign serial_value[PIN_CLK]   = serial_clk_out;

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
            level_sync u_sync (
                .sys_clk  (sys_clk),
                .rst      (rst),
                .async_in (pin_raw[gi]),
                .sync_out (pin_level[gi])
            );

            assign port_bits[gi].direction        = dir_ff[gi];
            assign port_bits[gi].data             = data_ff[gi];
            assign port_bits[gi].pulldown_inhibit = pdi_ff[gi];

            shared_pin_cell u_cell (
                .sys_clk       (sys_clk),
                .rst           (rst),
                .serial_enable (serial_enable_ff),
                .serial_drives (serial_drives[gi]),
                .serial_value  (serial_value[gi]),
                .port_bits     (port_bits[gi]),
                .drive         (drive[gi])
            );

            assign drive_oe[gi] = drive[gi].oe;
            assign drive_pd[gi] = drive[gi].pulldown_en;
            assign owned[gi]    = serial_enable_ff;
            // direction clear reads the pin, set reads the latch
            assign data_view[gi] = dir_ff[gi] ? data_ff[gi] : pin_level[gi];
        end
    endgenerate

    // register writes
    always_comb begin
        nxt_serial_enable = serial_enable_ff;
        nxt_master_select = master_select_ff;
        nxt_dir           = dir_ff;
        nxt_data          = data_ff;
        nxt_pdi           = pdi_ff;
        if (wr_take) begin
            unique case (sel)
                REG_SERIAL_CTRL: begin
                    nxt_serial_enable = pwdata[CTRL_ENABLE_BIT];
                    nxt_master_select = pwdata[CTRL_MASTER_BIT];
                end
                REG_PORT_DIR: begin
                    nxt_dir = port_field(pwdata);
                end
                REG_PORT_DATA: begin
                    nxt_data = port_field(pwdata);
                end
                REG_PULLDOWN_IN: begin
                    nxt_pdi = port_field(pwdata);
                end
                REG_PIN_STATUS: begin
                    nxt_pdi = pdi_ff;
                end
                REG_NONE: begin
                    nxt_pdi = pdi_ff;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            serial_enable_ff <= RST_SERIAL_ENABLE;
            master_select_ff <= RST_MASTER_SELECT;
            dir_ff           <= RST_DIR;
            data_ff          <= RST_DATA;
            pdi_ff           <= RST_PULLDOWN_IN;
        end else begin
            serial_enable_ff <= nxt_serial_enable;
            master_select_ff <= nxt_master_select;
            // port bits keep their values across serial use
            dir_ff           <= nxt_dir;
            data_ff          <= nxt_data;
            pdi_ff           <= nxt_pdi;
        end
    end

    // read data, captured in the setup cycle
    always_comb begin
        nxt_prdata = prdata_ff;
        if (setup_phase && !pwrite) begin
            unique case (sel)
                REG_SERIAL_CTRL: begin
                    nxt_prdata                  = 32'h0000_0000;
                    nxt_prdata[CTRL_ENABLE_BIT] = serial_enable_ff;
                    nxt_prdata[CTRL_MASTER_BIT] = master_select_ff;
                end
                REG_PORT_DIR: begin
                    nxt_prdata = port_word(dir_ff);
                end
                REG_PORT_DATA: begin
                    nxt_prdata = port_word(data_view);
                end
                REG_PULLDOWN_IN: begin
                    nxt_prdata = port_word(pdi_ff);
                end
                REG_PIN_STATUS: begin
                    nxt_prdata = 32'h0000_0000;
                    nxt_prdata[STAT_LEVEL_LSB +: 2] = pin_level;
                    nxt_prdata[STAT_OE_LSB +: 2]    = drive_oe;
                    nxt_prdata[STAT_PD_LSB +: 2]    = drive_pd;
                    nxt_prdata[STAT_OWN_LSB +: 2]   = owned;
                end
                REG_NONE: begin
                    nxt_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // clock from the peer into the serial unit when not master
    always_comb begin
        nxt_serial_clk_in = serial_clk_in_ff;
        if (serial_enable_ff && !master_select_ff) begin
            nxt_serial_clk_in = pin_level[PIN_CLK];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata_ff        <= 32'h0000_0000;
            serial_clk_in_ff <= 1'b0;
        end else begin
            prdata_ff        <= nxt_prdata;
            serial_clk_in_ff <= nxt_serial_clk_in;
        end
    end

    assign prdata        = prdata_ff;
    assign serial_clk_in = serial_clk_in_ff;
    assign serial_enable = serial_enable_ff;
    assign master_select = master_select_ff;

    // pin outputs
    assign shared_dout_pin_out         = drive[PIN_DOUT].out;
    assign shared_dout_pin_oe          = drive[PIN_DOUT].oe;
    assign shared_dout_pin_pulldown_en = drive[PIN_DOUT].pulldown_en;
    assign shared_clk_pin_out          = drive[PIN_CLK].out;
    assign shared_clk_pin_oe           = drive[PIN_CLK].oe;
    assign shared_clk_pin_pulldown_en  = drive[PIN_CLK].pulldown_en;

endmodule
`default_nettype wire

// File: hdl/shared_pin_cell.sv
`timescale 1ns/10ps
`default_nettype none

module shared_pin_cell
    import pin_share_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // serial unit side
    input  wire logic          serial_enable,
    input  wire logic          serial_drives,
    input  wire logic          serial_value,
    // port side
    input  wire port_bits_type port_bits,
    // pin side
    output pin_drive_type      drive
);

    pin_drive_type drive_ff;
    pin_drive_type nxt_drive;

    always_comb begin
        if (serial_enable) begin
            nxt_drive.oe          = serial_drives;
            nxt_drive.out         = serial_value;
            nxt_drive.pulldown_en = 1'b0;
        end else begin
            nxt_drive.oe          = port_bits.direction;
            nxt_drive.out         = port_bits.data;
            nxt_drive.pulldown_en = !port_bits.pulldown_inhibit;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            drive_ff <= '0;
        end else begin
            drive_ff <= nxt_drive;
        end
    end

    assign drive = drive_ff;

endmodule
`default_nettype wire

// File: pkg/pin_share_pkg.sv
package pin_share_pkg;

    localparam int PIN_COUNT = 2;
    localparam int PIN_DOUT  = 0;
    localparam int PIN_CLK   = 1;

    localparam logic [11:0] OFS_SERIAL_CTRL = 12'h000;
    localparam logic [11:0] OFS_PORT_DIR    = 12'h004;
    localparam logic [11:0] OFS_PORT_DATA   = 12'h008;
    localparam logic [11:0] OFS_PULLDOWN_IN = 12'h00c;
    localparam logic [11:0] OFS_PIN_STATUS  = 12'h010;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_MASTER_BIT = 1;
    localparam int PORT_DOUT_BIT   = 5;
    localparam int PORT_CLK_BIT    = 7;

    localparam int STAT_LEVEL_LSB  = 0;
    localparam int STAT_OE_LSB     = 4;
    localparam int STAT_PD_LSB     = 8;
    localparam int STAT_OWN_LSB    = 12;

    localparam logic       RST_SERIAL_ENABLE = 1'b0;
    localparam logic       RST_MASTER_SELECT = 1'b0;
    localparam logic [1:0] RST_DIR           = 2'h0;
    localparam logic [1:0] RST_DATA          = 2'h0;
    localparam logic [1:0] RST_PULLDOWN_IN   = 2'h0;

    typedef enum {
        REG_SERIAL_CTRL,
        REG_PORT_DIR,
        REG_PORT_DATA,
        REG_PULLDOWN_IN,
        REG_PIN_STATUS,
        REG_NONE
    } reg_sel_type;

    typedef struct packed {
        logic direction;
        logic data;
        logic pulldown_inhibit;
    } port_bits_type;

    typedef struct packed {
        logic oe;
        logic out;
        logic pulldown_en;
    } pin_drive_type;

endpackage

// File: testbench/pin_share_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pin_share_assertions import pin_share_pkg::*; (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // serial unit
    input wire logic        serial_data_out,
    input wire logic        serial_clk_out,
    input wire logic        serial_enable,
    input wire logic        master_select,
    // pins
    input wire logic        shared_dout_pin_out,
    input wire logic        shared_dout_pin_oe,
    input wire logic        shared_dout_pin_pulldown_en,
    input wire logic        shared_clk_pin_out,
    input wire logic        shared_clk_pin_oe,
    input wire logic        shared_clk_pin_pulldown_en
);
    logic       acc;
    logic       bad;
    logic [5:0] pins;
    assign acc = psel && penable;
    assign bad = !(paddr inside {OFS_SERIAL_CTRL, OFS_PORT_DIR, OFS_PORT_DATA, OFS_PULLDOWN_IN, OFS_PIN_STATUS})
        || (pwrite && paddr == OFS_PIN_STATUS);
    assign pins = {shared_dout_pin_out, shared_dout_pin_oe, shared_dout_pin_pulldown_en,
        shared_clk_pin_out, shared_clk_pin_oe, shared_clk_pin_pulldown_en};
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    dout_serial_a: assert property (serial_enable |=> shared_dout_pin_oe && !shared_dout_pin_pulldown_en
        && shared_dout_pin_out == $past(serial_data_out)) else $error("data pin not serial");
    clk_master_a: assert property (serial_enable && master_select |=> shared_clk_pin_oe
        && shared_clk_pin_out == $past(serial_clk_out)) else $error("clock pin not driven");
    clk_slave_a: assert property (serial_enable && !master_select |=> !shared_clk_pin_oe)
        else $error("clock pin not released");
    clk_pulldown_a: assert property (serial_enable |=> !shared_clk_pin_pulldown_en)
        else $error("clock pulldown on");
    port_hold_a: assert property (!(acc && pwrite) && !serial_enable |-> ##2 $stable(pins))
        else $error("port pins moved");
    bad_access_a: assert property (acc && bad |-> pslverr)
        else $error("no error response");
    good_access_a: assert property (acc && !bad |-> !pslverr)
        else $error("false error response");
    ctrl_copy_a: assert property (acc && pwrite && paddr == OFS_SERIAL_CTRL |=>
        serial_enable == $past(pwdata[CTRL_ENABLE_BIT]) && master_select == $past(pwdata[CTRL_MASTER_BIT]))
        else $error("control bits not taken");
endmodule
`default_nettype wire

// File: testbench/serial_peer.sv
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
    // clock
    input  wire logic       sys_clk,
    // device drive, index 0 data pin, 1 clock pin
    input  wire logic [1:0] oe,
    input  wire logic [1:0] out,
    input  wire logic [1:0] pd,
    // peer drive and clock frames
    input  wire logic [1:0] drv,
    input  wire logic [1:0] val,
    input  wire logic       frame,
    input  wire logic [3:0] half,
    // wire levels
    output logic      [1:0] lvl
);
    logic [1:0] last = 2'h0;
    logic [3:0] cnt  = 4'h0;
    logic       tgl  = 1'h0;
    // released and unpulled lines flip each cycle
    assign lvl = (oe & out) | (~oe & drv & {tgl, val[0]}) | (~oe & ~drv & ~pd & ~last);
    always @(posedge sys_clk) begin
        last <= lvl;
        cnt  <= (frame && cnt < half - 4'h1) ? cnt + 4'h1 : 4'h0;
        if (!frame) begin
            tgl <= val[1];
        end else if (cnt >= half - 4'h1) begin
            tgl <= ~tgl;
        end
    end
endmodule
`default_nettype wire

// File: testbench/serial_port_pin_sharing_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module serial_port_pin_sharing_tb_top import pin_share_pkg::*;;
    logic        sys_clk = 1'h0;
    logic        rst = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic        serial_data_out = 1'h0;
    logic        serial_clk_out = 1'h0;
    logic [1:0]  drv = 2'h0;
    logic [1:0]  val = 2'h0;
    logic        frame = 1'h0;
    logic [3:0]  half = 4'h1;
    logic        pready, pslverr, serial_clk_in, serial_enable, master_select, clk_seen;
    logic [31:0] prdata;
    logic        shared_dout_pin_in, shared_dout_pin_out, shared_dout_pin_oe, shared_dout_pin_pulldown_en;
    logic        shared_clk_pin_in, shared_clk_pin_out, shared_clk_pin_oe, shared_clk_pin_pulldown_en;
    logic [31:0] exp_q[$];
    int          fails = 0;
    int          samples_checked = 0;
    int          edges_seen = 0;

    serial_port_pin_sharing DUT (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
        .prdata, .serial_data_out, .serial_clk_out, .serial_clk_in, .serial_enable, .master_select,
        .shared_dout_pin_in, .shared_dout_pin_out, .shared_dout_pin_oe, .shared_dout_pin_pulldown_en,
        .shared_clk_pin_in, .shared_clk_pin_out, .shared_clk_pin_oe, .shared_clk_pin_pulldown_en);
    serial_peer peer (.sys_clk, .oe({shared_clk_pin_oe, shared_dout_pin_oe}),
        .out({shared_clk_pin_out, shared_dout_pin_out}),
        .pd({shared_clk_pin_pulldown_en, shared_dout_pin_pulldown_en}), .drv, .val, .frame, .half,
        .lvl({shared_clk_pin_in, shared_dout_pin_in}));

    always #50 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [31:0] e, s);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask

    // read results and serial clock edges at the far side
    always @(posedge sys_clk) begin
        if (serial_clk_in !== clk_seen) begin
            edges_seen++;
        end
        clk_seen = serial_clk_in;
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            check("prdata", exp_q.pop_front(), prdata);
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'h1);
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'h0, a, 32'h0);
    endtask

    function automatic logic [31:0] pb(input logic [1:0] b);
        pb = 32'h0;
        pb[PORT_DOUT_BIT] = b[PIN_DOUT];
        pb[PORT_CLK_BIT]  = b[PIN_CLK];
    endfunction

    function automatic logic [31:0] st(input logic [1:0] lv, oe, pd, own);
        st = {18'h0, own, 2'h0, pd, 2'h0, oe, 2'h0, lv};
    endfunction

    task automatic port_chk(input logic [1:0] dir, dat, inh, pe, pv);
        logic [1:0] lv;
        lv  = (dir & dat) | (~dir & pe & pv);
        drv <= pe;
        val <= pv;
        repeat (4) @(posedge sys_clk);
        rd(OFS_PIN_STATUS, st(lv, dir, ~inh, 2'h0));
        rd(OFS_PORT_DATA, pb(lv));
    endtask

    task automatic wrap_up();
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        logic [1:0] dir, dat, inh, pe, pv, lv;
        logic       m, sd, sc;
        void'($urandom(42));
        rst = 1'h1;
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        rd(OFS_SERIAL_CTRL, 32'h0);
        rd(OFS_PULLDOWN_IN, 32'h0);
        rd(12'h014, 32'h0);
        wr(OFS_PIN_STATUS, 32'hffffffff);
        port_chk(2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
        for (int i = 0; i < 10; i++) begin
            {dir, dat, inh, pv} = 8'($urandom);
            pe = ~dir & (2'($urandom) | inh);
            wr(OFS_PORT_DIR, pb(dir));
            wr(OFS_PORT_DATA, pb(dat));
            wr(OFS_PULLDOWN_IN, pb(inh));
            rd(OFS_PORT_DIR, pb(dir));
            port_chk(dir, dat, inh, pe, pv);
        end
        for (int k = 0; k < 4; k++) begin
            m = k[0];
            {dir, dat, pv, sd, sc} = 8'($urandom);
            half            <= k[1] ? 4'h3 : 4'h1;
            serial_data_out <= sd;
            serial_clk_out  <= sc;
            drv             <= {~m, 1'h0};
            val             <= pv;
            wr(OFS_SERIAL_CTRL, {30'h0, m, 1'h1});
            wr(OFS_PORT_DIR, pb(dir));
            wr(OFS_PORT_DATA, pb(dat));
            repeat (4) @(posedge sys_clk);
            lv = {m ? sc : pv[PIN_CLK], sd};
            rd(OFS_PIN_STATUS, st(lv, {m, 1'h1}, 2'h0, 2'h3));
            rd(OFS_PORT_DIR, pb(dir));
            rd(OFS_PORT_DATA, pb((dir & dat) | (~dir & lv)));
            if (!m) begin
                edges_seen = 0;
                frame <= 1'h1;
                repeat (16 * half) @(posedge sys_clk);
                frame <= 1'h0;
                repeat (6) @(posedge sys_clk);
                check("clock edges", 32'h10, 32'(edges_seen));
            end
        end
        wr(OFS_SERIAL_CTRL, 32'h0);
        port_chk(dir, dat, inh, ~dir & (pv | inh), pv);
        wrap_up();
    end

    initial begin
        #2ms;
        fails++;
        $display("MISMATCH watchdog expected finish seen timeout");
        wrap_up();
    end
endmodule

bind serial_port_pin_sharing pin_share_assertions chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pslverr, .serial_data_out, .serial_clk_out, .serial_enable, .master_select, .shared_dout_pin_out,
    .shared_dout_pin_oe, .shared_dout_pin_pulldown_en, .shared_clk_pin_out, .shared_clk_pin_oe,
    .shared_clk_pin_pulldown_en);
`default_nettype wire
